// *** src/modlim_pkg.sv ***
// Shared constants and types for the modulation limit and feedforward config block
package modlim_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DEB_SHORT_MS  = 5;
  localparam int unsigned DEB_LONG_MS   = 10;
  localparam int unsigned DEB_SHORT_CYC = DEB_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DEB_LONG_CYC  = DEB_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DEB_CNT_W     = 17;
  localparam int unsigned ADDR_W        = 18;
  localparam int unsigned MOD_NS_W      = 15;
  // Register indices, byte address is four times the index
  localparam logic [15:0] IDX_CHAN_A_LIMIT = 16'hfe3c;
  localparam logic [15:0] IDX_CHAN_B_LIMIT = 16'hfe3d;
  localparam logic [15:0] IDX_CHAN_A_CFG   = 16'hfe3e;
  localparam logic [15:0] IDX_FREQ_BAND    = 16'hff00;
  localparam logic [15:0] IDX_STATUS       = 16'hff01;
  // Reset values
  localparam logic [7:0]  LIMIT_RST = 8'h00;
  localparam logic [7:0]  CFG_RST   = 8'h08;
  // Configuration and status field positions
  localparam int unsigned CFG_DEB_LONG_BIT = 5;
  localparam int unsigned CFG_DEB_EN_BIT   = 4;
  localparam int unsigned CFG_FFWD_SEL_BIT = 3;
  localparam int unsigned CFG_FFWD_EN_BIT  = 2;
  localparam int unsigned CFG_GAIN_LSB     = 0;
  localparam int unsigned STAT_SETTLED_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT    = 1;
  // Step of one limit LSB per frequency band
  localparam logic [6:0]  LSB_NS_49K  = 7'h50;
  localparam logic [6:0]  LSB_NS_98K  = 7'h28;
  localparam logic [6:0]  LSB_NS_195K = 7'h14;
  localparam logic [6:0]  LSB_NS_391K = 7'h0a;

  typedef enum logic [1:0] {
    BAND_49K  = 2'h0,
    BAND_98K  = 2'h1,
    BAND_195K = 2'h2,
    BAND_391K = 2'h3
  } band_t;

  typedef enum logic [1:0] {
    DEB_IDLE  = 2'h0,
    DEB_COUNT = 2'h1,
    DEB_DONE  = 2'h3
  } deb_state_t;

  function automatic logic [6:0] lsb_ns(input band_t b);
    case (b)
      BAND_49K:  return LSB_NS_49K;
      BAND_98K:  return LSB_NS_98K;
      BAND_195K: return LSB_NS_195K;
      default:   return LSB_NS_391K;
    endcase
  endfunction
endpackage

// *** src/deb_if.sv ***
// Settling debounce control and result between config and timer
`timescale 1ns/1ns
interface deb_if;
  logic en;
  logic long_sel;
  logic active;
  logic raw;
  logic settled;
  logic busy;
  modport ctl (output en, long_sel, active, raw, input settled, busy);
  modport tmr (input en, long_sel, active, raw, output settled, busy);
endinterface

// *** src/mod_scale.sv ***
// Converts a modulation limit code to a time in ns for the active band
`timescale 1ns/1ns
module mod_scale (
  // Clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // Limit code and band
  input  wire logic [7:0]                       limit,
  input  wire modlim_pkg::band_t                band,
  // Scaled limit
  output logic [modlim_pkg::MOD_NS_W-1:0]       ns_q
);
  logic [modlim_pkg::MOD_NS_W-1:0] ns_d;

  // Limit is the widest edge shift from the default edge, in band steps
  assign ns_d = {7'h00, limit} * {8'h00, modlim_pkg::lsb_ns(band)};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ns_q <= '0;
    end else begin
      ns_q <= ns_d;
    end
  end
endmodule

// *** src/deb_timer.sv ***
// Settling debounce timer for the high frequency sense ADC
`timescale 1ns/1ns
module deb_timer #(
  parameter int unsigned SHORT_CYC = modlim_pkg::DEB_SHORT_CYC,
  parameter int unsigned LONG_CYC  = modlim_pkg::DEB_LONG_CYC,
  parameter int unsigned CNT_W     = modlim_pkg::DEB_CNT_W
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Debounce port
  deb_if.tmr        d
);
  modlim_pkg::deb_state_t state_q, state_d;
  logic [CNT_W-1:0]       cnt_q, cnt_d;
  wire  [CNT_W-1:0]       last_cnt;
  wire                    go;

  assign go       = d.active & d.raw;
  assign last_cnt = d.long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      modlim_pkg::DEB_IDLE: begin
        cnt_d = '0;
        if (go) begin
          state_d = d.en ? modlim_pkg::DEB_COUNT : modlim_pkg::DEB_DONE;
        end
      end
      modlim_pkg::DEB_COUNT: begin
        if (!go) begin
          state_d = modlim_pkg::DEB_IDLE;
        end else if (!d.en || cnt_q == last_cnt) begin
          state_d = modlim_pkg::DEB_DONE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      modlim_pkg::DEB_DONE: begin
        if (!go) begin
          state_d = modlim_pkg::DEB_IDLE;
        end
      end
      default: state_d = modlim_pkg::DEB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= modlim_pkg::DEB_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign d.settled = (state_q == modlim_pkg::DEB_DONE);
  assign d.busy    = (state_q == modlim_pkg::DEB_COUNT);
endmodule

// *** src/modlim_cfg.sv ***
// APB register block for modulation limits, feedforward and soft-start settings
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module modlim_cfg #(
  parameter int unsigned ADDR_W        = modlim_pkg::ADDR_W,
  parameter int unsigned DEB_SHORT_CYC = modlim_pkg::DEB_SHORT_CYC,
  parameter int unsigned DEB_LONG_CYC  = modlim_pkg::DEB_LONG_CYC,
  parameter int unsigned DEB_W         = modlim_pkg::DEB_CNT_W
) (
  // Clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [ADDR_W-1:0]                 paddr,
  input  wire logic [31:0]                       pwdata,
  output logic                                   pready,
  output logic [31:0]                            prdata,
  output logic                                   pslverr,
  // Soft-start sense
  input  wire logic                              soft_start_active,
  input  wire logic                              hf_adc_ready,
  // Control outputs
  output logic [modlim_pkg::MOD_NS_W-1:0]        chan_a_mod_limit_ns,
  output logic [modlim_pkg::MOD_NS_W-1:0]        chan_b_mod_limit_ns,
  output logic                                   ffwd_en,
  output logic                                   ffwd_line_adc_sel,
  output logic [3:0]                             ss_filter_gain,
  output logic                                   hf_adc_settled
);
  if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 18 to 32");
  end
  if (DEB_SHORT_CYC < 1 || DEB_LONG_CYC < DEB_SHORT_CYC) begin : g_bad_deb
    $error("debounce counts out of order");
  end
  if (DEB_LONG_CYC > (64'd1 << DEB_W)) begin : g_bad_w
    $error("DEB_W too narrow for debounce count");
  end

  function automatic logic word_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  // Register state
  logic [7:0]          lim_a_q;
  logic [7:0]          lim_b_q;
  logic [7:0]          cfg_a_q;
  modlim_pkg::band_t   band_q;
  logic                pready_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic                ffwd_en_q;
  logic                ffwd_sel_q;
  logic [3:0]          gain_q;
  logic                settled_q;

  // Bus decode
  wire        setup;
  wire        wr_en;
  wire        hit_lim_a;
  wire        hit_lim_b;
  wire        hit_cfg;
  wire        hit_band;
  wire        hit_stat;
  wire        any_hit;
  wire [7:0]  status;
  wire [7:0]  rd_byte;
  wire [31:0] prdata_d;
  wire [3:0]  gain_d;

  deb_if dbi ();

  assign setup     = psel & ~penable;
  assign wr_en     = psel & penable & pready_q & pwrite;
  assign hit_lim_a = word_hit(paddr, modlim_pkg::IDX_CHAN_A_LIMIT);
  assign hit_lim_b = word_hit(paddr, modlim_pkg::IDX_CHAN_B_LIMIT);
  assign hit_cfg   = word_hit(paddr, modlim_pkg::IDX_CHAN_A_CFG);
  assign hit_band  = word_hit(paddr, modlim_pkg::IDX_FREQ_BAND);
  assign hit_stat  = word_hit(paddr, modlim_pkg::IDX_STATUS);
  assign any_hit   = hit_lim_a | hit_lim_b | hit_cfg | hit_band | hit_stat;

  assign status = {6'h00, dbi.busy, dbi.settled};

  assign rd_byte = hit_lim_a ? lim_a_q :
                   hit_lim_b ? lim_b_q :
                   hit_cfg   ? cfg_a_q :
                   hit_band  ? {6'h00, band_q} :
                   hit_stat  ? status : 8'h00;

  // Read data is captured in the setup cycle so the access cycle needs no wait
  assign prdata_d = (setup & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      prdata_q  <= prdata_d;
      pslverr_q <= setup & ~any_hit;
    end
  end

  // Limits, one per channel, written independently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_a_q <= modlim_pkg::LIMIT_RST;
      lim_b_q <= modlim_pkg::LIMIT_RST;
    end else begin
      if (wr_en && hit_lim_a) begin
        lim_a_q <= pwdata[7:0];
      end
      if (wr_en && hit_lim_b) begin
        lim_b_q <= pwdata[7:0];
      end
    end
  end

  // Config byte resets with the line sense ADC selected; reserved bits are kept as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_q <= modlim_pkg::CFG_RST;
      band_q  <= modlim_pkg::BAND_49K;
    end else begin
      if (wr_en && hit_cfg) begin
        cfg_a_q <= pwdata[7:0];
      end
      if (wr_en && hit_band) begin
        band_q <= modlim_pkg::band_t'(pwdata[1:0]);
      end
    end
  end

  // Gain is 1 shifted by the two-bit code
  assign gain_d = 4'h1 << cfg_a_q[modlim_pkg::CFG_GAIN_LSB +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ffwd_en_q  <= 1'b0;
      ffwd_sel_q <= 1'b1;
      gain_q     <= 4'h1;
      settled_q  <= 1'b0;
    end else begin
      ffwd_en_q  <= cfg_a_q[modlim_pkg::CFG_FFWD_EN_BIT];
      ffwd_sel_q <= cfg_a_q[modlim_pkg::CFG_FFWD_SEL_BIT];
      gain_q     <= gain_d;
      settled_q  <= dbi.settled;
    end
  end

  // Debounce timer; bit 5 only matters while bit 4 enables it
  assign dbi.en       = cfg_a_q[modlim_pkg::CFG_DEB_EN_BIT];
  assign dbi.long_sel = cfg_a_q[modlim_pkg::CFG_DEB_LONG_BIT];
  assign dbi.active   = soft_start_active;
  assign dbi.raw      = hf_adc_ready;

  deb_timer #(
    .SHORT_CYC (DEB_SHORT_CYC),
    .LONG_CYC  (DEB_LONG_CYC),
    .CNT_W     (DEB_W)
  ) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (dbi)
  );

  // Each channel scales its own limit by the shared band
  mod_scale u_scale_a (
    .pclk    (pclk),
    .presetn (presetn),
    .limit   (lim_a_q),
    .band    (band_q),
    .ns_q    (chan_a_mod_limit_ns)
  );

  mod_scale u_scale_b (
    .pclk    (pclk),
    .presetn (presetn),
    .limit   (lim_b_q),
    .band    (band_q),
    .ns_q    (chan_b_mod_limit_ns)
  );

  assign pready            = pready_q;
  assign prdata            = prdata_q;
  assign pslverr           = pslverr_q;
  assign ffwd_en           = ffwd_en_q;
  assign ffwd_line_adc_sel = ffwd_sel_q;
  assign ss_filter_gain    = gain_q;
  assign hf_adc_settled    = settled_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Helper: length of the last debounce run, read only by the checks
  logic [DEB_W:0] busy_len_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len_q <= '0;
    end else if (dbi.busy) begin
      busy_len_q <= busy_len_q + 1'b1;
    end else if (!dbi.settled) begin
      busy_len_q <= '0;
    end
  end

  sequence s_wr_lim_a;
    wr_en && hit_lim_a;
  endsequence

  sequence s_wr_lim_b;
    wr_en && hit_lim_b;
  endsequence

  sequence s_wr_cfg;
    wr_en && hit_cfg;
  endsequence

  sequence s_go_bypass;
    (!dbi.en && soft_start_active && hf_adc_ready) [*2];
  endsequence

  a_lim_a_scaled: assert property (
    s_wr_lim_a |=> ##1 chan_a_mod_limit_ns ==
      {7'h00, $past(pwdata[7:0], 2)} * {8'h00, modlim_pkg::lsb_ns(band_q)})
    else $error("channel A limit not scaled from written code");

  a_lim_b_scaled: assert property (
    s_wr_lim_b |=> ##1 chan_b_mod_limit_ns ==
      {7'h00, $past(pwdata[7:0], 2)} * {8'h00, modlim_pkg::lsb_ns(band_q)})
    else $error("channel B limit not scaled from written code");

  a_lim_b_apart: assert property (
    s_wr_lim_a |=> $stable(lim_b_q) ##1 $stable(chan_b_mod_limit_ns))
    else $error("channel A write disturbed channel B limit");

  a_band_step: assert property (
    (band_q == modlim_pkg::BAND_391K && lim_a_q == 8'h01) [*2]
      |-> chan_a_mod_limit_ns == 15'h000a)
    else $error("one step in top band is not 10 ns");

  a_lim_full_range: assert property (
    (band_q == modlim_pkg::BAND_49K && lim_b_q == 8'hff) [*2]
      |-> chan_b_mod_limit_ns == 15'h4fb0)
    else $error("full limit in lowest band is not 20400 ns");

  a_deb_length: assert property (
    $rose(dbi.settled) && $past(dbi.busy) && dbi.en
      |-> busy_len_q == (dbi.long_sel ? DEB_LONG_CYC : DEB_SHORT_CYC))
    else $error("debounce run length does not match selection");

  a_deb_bypass: assert property (
    s_go_bypass |=> hf_adc_settled)
    else $error("settled not reported without debounce");

  a_deb_drop: assert property (
    !(soft_start_active && hf_adc_ready) |=> ##1 !hf_adc_settled)
    else $error("settled held after sense dropped");

  a_ffwd_enable: assert property (
    s_wr_cfg |=> ##1 ffwd_en == $past(pwdata[modlim_pkg::CFG_FFWD_EN_BIT], 2))
    else $error("feedforward enable not following config");

  a_ffwd_source: assert property (
    s_wr_cfg |=> ##1 ffwd_line_adc_sel == $past(pwdata[modlim_pkg::CFG_FFWD_SEL_BIT], 2))
    else $error("feedforward source not following config");

  a_gain_eight: assert property (
    s_wr_cfg ##0 (pwdata[1:0] == 2'h3) |=> ##1 ss_filter_gain == 4'h8)
    else $error("gain code 3 did not give 8");

  a_apb_answer: assert property (
    setup |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");

  // Read data mirrors the state sampled at the setup edge
  sequence s_rd;
    setup && !pwrite;
  endsequence

  sequence s_wr_miss;
    psel && penable && pwrite && !any_hit;
  endsequence

  a_rd_lim_a: assert property (
    s_rd ##0 hit_lim_a |=> prdata == {24'h000000, $past(lim_a_q)})
    else $error("channel A limit read back wrong");

  a_rd_lim_b: assert property (
    s_rd ##0 hit_lim_b |=> prdata == {24'h000000, $past(lim_b_q)})
    else $error("channel B limit read back wrong");

  a_rd_cfg: assert property (
    s_rd ##0 hit_cfg |=> prdata[7:0] == $past(cfg_a_q))
    else $error("config byte read back wrong");

  a_rd_band: assert property (
    s_rd ##0 hit_band |=> prdata[1:0] == $past(band_q))
    else $error("band read back wrong");

  a_rd_stat: assert property (
    s_rd ##0 hit_stat |=> prdata[1:0] == $past({dbi.busy, dbi.settled}))
    else $error("status read back wrong");

  a_bad_addr: assert property (
    setup && !any_hit |=> pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  a_wr_miss: assert property (
    s_wr_miss |=> $stable(lim_a_q) && $stable(lim_b_q) && $stable(cfg_a_q))
    else $error("unmapped write changed a register");

  a_deb_busy_en: assert property (
    dbi.busy |-> $past(dbi.en))
    else $error("debounce counting while disabled");

  a_settled_go: assert property (
    dbi.settled |-> $past(dbi.active && dbi.raw))
    else $error("settled without soft start sense");

  a_gain_one: assert property (
    s_wr_cfg ##0 (pwdata[1:0] == 2'h0) |=> ##1 ss_filter_gain == 4'h1)
    else $error("gain code 0 did not give 1");

  a_gain_two: assert property (
    s_wr_cfg ##0 (pwdata[1:0] == 2'h1) |=> ##1 ss_filter_gain == 4'h2)
    else $error("gain code 1 did not give 2");

  a_gain_four: assert property (
    s_wr_cfg ##0 (pwdata[1:0] == 2'h2) |=> ##1 ss_filter_gain == 4'h4)
    else $error("gain code 2 did not give 4");
endmodule

// *** bench/test_pwm_modulation_limit_ffwd_cfg.sv ***
// Self-checking bench for the modulation limit and feedforward config block
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_pwm_modulation_limit_ffwd_cfg;
  localparam int unsigned SHORT_N = 8;
  localparam int unsigned LONG_N  = 16;
  localparam logic [17:0] adr_lim_a = {modlim_pkg::IDX_CHAN_A_LIMIT, 2'h0};
  localparam logic [17:0] adr_lim_b = {modlim_pkg::IDX_CHAN_B_LIMIT, 2'h0};
  localparam logic [17:0] adr_cfg   = {modlim_pkg::IDX_CHAN_A_CFG, 2'h0};
  localparam logic [17:0] adr_band  = {modlim_pkg::IDX_FREQ_BAND, 2'h0};
  localparam logic [17:0] adr_stat  = {modlim_pkg::IDX_STATUS, 2'h0};
  localparam logic [17:0] adr_map [4] = '{adr_lim_a, adr_lim_b, adr_cfg, adr_band};
  // Clock and reset
  logic        pclk;
  logic        presetn;
  // APB
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  // Soft start sense and outputs
  logic        soft_start_active;
  logic        hf_adc_ready;
  logic [14:0] chan_a_mod_limit_ns;
  logic [14:0] chan_b_mod_limit_ns;
  logic        ffwd_en;
  logic        ffwd_line_adc_sel;
  logic [3:0]  ss_filter_gain;
  logic        hf_adc_settled;
  int          error_cnt;
  int          total_checks;
  logic [31:0] seed;
  int          n_set [4];
  // Model registers: limit A, limit B, config, band
  int          mdl [4];

  modlim_cfg #(.DEB_SHORT_CYC(SHORT_N), .DEB_LONG_CYC(LONG_N)) u_modlim_cfg (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .soft_start_active(soft_start_active), .hf_adc_ready(hf_adc_ready),
    .chan_a_mod_limit_ns(chan_a_mod_limit_ns), .chan_b_mod_limit_ns(chan_b_mod_limit_ns),
    .ffwd_en(ffwd_en), .ffwd_line_adc_sel(ffwd_line_adc_sel),
    .ss_filter_gain(ss_filter_gain), .hf_adc_settled(hf_adc_settled)
  );

  always #50 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Master holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, exp)
    `CHK(e, eerr)
  endtask

  task automatic wr_chk(input logic [17:0] a, input logic [31:0] d, input logic eerr);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    `CHK(e, eerr)
    if (!eerr) begin
      for (int k = 0; k < 4; k++) begin
        if (a == adr_map[k]) begin
          mdl[k] = (k == 3) ? int'(d[1:0]) : int'(d[7:0]);
        end
      end
    end
  endtask

  // Counts edges until settled reaches the wanted level, bounded
  task automatic wait_set(input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (hf_adc_settled !== lvl && n < 200);
    if (n >= 200) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic go(input logic v);
    @(posedge pclk);
    soft_start_active <= v;
    hf_adc_ready <= v;
  endtask

  initial begin
    logic [7:0]  la;
    logic [7:0]  lb;
    logic [7:0]  v;
    logic [31:0] r;
    logic        e;
    int          n;
    logic [7:0]  cfgs [4];
    pclk = 1'b0;
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= '0;
    pwdata <= '0;
    soft_start_active <= 1'b0;
    hf_adc_ready <= 1'b0;
    error_cnt = 0;
    total_checks = 0;
    seed = 32'he20419c5;
    mdl = '{int'(modlim_pkg::LIMIT_RST), int'(modlim_pkg::LIMIT_RST),
            int'(modlim_pkg::CFG_RST), int'(modlim_pkg::BAND_49K)};
    cfgs = '{8'h08, 8'h18, 8'h38, 8'h28};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #10;
    `CHK(ffwd_line_adc_sel, 1'b1)
    `CHK(ss_filter_gain, 4'h1)
    rd_chk(adr_lim_a, 32'h0, 1'b0);
    rd_chk(adr_lim_b, 32'h0, 1'b0);
    rd_chk(adr_cfg, 32'h08, 1'b0);
    rd_chk(adr_band, 32'h0, 1'b0);
    // Unmapped and misaligned places answer with an error and no data
    rd_chk(adr_cfg + 18'h4, 32'h0, 1'b1);
    wr_chk(adr_lim_a + 18'h1, 32'hff, 1'b1);
    wr_chk(adr_stat, 32'hff, 1'b0);
    rd_chk(adr_lim_a, 32'h0, 1'b0);
    // Every band with random limits, upper write bits must be dropped
    for (int b = 0; b < 4; b++) begin
      wr_chk(adr_band, 32'(b), 1'b0);
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        la = (k == 0) ? 8'h01 : seed[7:0];
        lb = (k == 0) ? 8'hff : seed[15:8];
        wr_chk(adr_lim_a, {seed[31:8], la}, 1'b0);
        wr_chk(adr_lim_b, {seed[31:8], lb}, 1'b0);
        repeat (3) @(posedge pclk);
        #10;
        `CHK(chan_a_mod_limit_ns, 15'(mdl[0] * (80 >> mdl[3])))
        `CHK(chan_b_mod_limit_ns, 15'(mdl[1] * (80 >> mdl[3])))
        rd_chk(adr_lim_a, 32'(mdl[0]), 1'b0);
        rd_chk(adr_lim_b, 32'(mdl[1]), 1'b0);
      end
    end
    // All gain codes, feedforward on and off, source bit always kept high
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = {seed[7:6], 3'b001, i[2:0]};
      wr_chk(adr_cfg, {seed[31:8], v}, 1'b0);
      repeat (2) @(posedge pclk);
      #10;
      `CHK(ffwd_en, mdl[2][modlim_pkg::CFG_FFWD_EN_BIT])
      `CHK(ffwd_line_adc_sel, mdl[2][modlim_pkg::CFG_FFWD_SEL_BIT])
      `CHK(ss_filter_gain, 4'(1 << mdl[2][1:0]))
      rd_chk(adr_cfg, 32'(mdl[2]), 1'b0);
    end
    // Debounce off, short, long, and time bit without enable
    for (int i = 0; i < 4; i++) begin
      wr_chk(adr_cfg, {24'h0, cfgs[i]}, 1'b0);
      go(1'b1);
      wait_set(1'b1, n_set[i]);
      if (cfgs[i][4]) begin
        apb(1'b0, adr_stat, 32'h0, r, e);
        `CHK(r[1:0], 2'h1)
      end
      go(1'b0);
      wait_set(1'b0, n);
      `CHK(n <= 3, 1'b1)
    end
    `CHK(n_set[0] <= 3, 1'b1)
    `CHK(n_set[3], n_set[0])
    `CHK(n_set[1] >= SHORT_N && n_set[1] <= SHORT_N + 4, 1'b1)
    `CHK(n_set[2] - n_set[1], int'(LONG_N - SHORT_N))
    // A drop in mid-count restarts the short count
    wr_chk(adr_cfg, 32'h18, 1'b0);
    go(1'b1);
    repeat (4) @(posedge pclk);
    hf_adc_ready <= 1'b0;
    @(posedge pclk);
    hf_adc_ready <= 1'b1;
    wait_set(1'b1, n);
    `CHK(n, n_set[1])
    go(1'b0);
    repeat (4) @(posedge pclk);
    finish_test();
  end
endmodule
